/* File: lhb_consts.svh */
`ifndef LHB_CONSTS_SVH
`define LHB_CONSTS_SVH

// ----------------------------------------------------------------------
// geometry of display memory
// ----------------------------------------------------------------------
`define LHB_PAGES          8
`define LHB_COLS           128
`define LHB_FIFO_DEPTH     16

// ----------------------------------------------------------------------
// control byte codes and the bits that must match them
// ----------------------------------------------------------------------
`define LHB_ONOFF_CODE     8'hae
`define LHB_ONOFF_MASK     8'hfe
`define LHB_START_CODE     8'h40
`define LHB_START_MASK     8'hc0
`define LHB_PAGE_CODE      8'hb0
`define LHB_PAGE_MASK      8'hf0
`define LHB_COLH_CODE      8'h10
`define LHB_COLL_CODE      8'h00
`define LHB_NIB_MASK       8'hf0
`define LHB_ADC_CODE       8'ha0
`define LHB_INV_CODE       8'ha6
`define LHB_ALL_CODE       8'ha4
`define LHB_BIAS_CODE      8'ha2
`define LHB_STATIC_CODE    8'hac
`define LHB_BIT0_MASK      8'hfe
`define LHB_RMW_CODE       8'he0
`define LHB_END_CODE       8'hee
`define LHB_RESET_CODE     8'he2
`define LHB_COM_CODE       8'hc0
`define LHB_COM_MASK       8'hf0
`define LHB_COM_BIT        3
`define LHB_PWR_CODE       8'h28
`define LHB_RATIO_CODE     8'h20
`define LHB_LOW3_MASK      8'hf8
`define LHB_VOL_CODE       8'h81
`define LHB_BOOST_CODE     8'hf8
`define LHB_BOOST_BAD      2'h2

// ----------------------------------------------------------------------
// reset values and serial pin layout
// ----------------------------------------------------------------------
`define LHB_VOLUME_RST     6'h20
`define LHB_SERIAL_LAST    3'h7
`define LHB_SCL_BIT        6
`define LHB_SI_BIT         7

`endif

/* File: lhb_pkg.sv */
`include "lhb_consts.svh"

package lhb_pkg;

  // pending operand of a two-byte command, gray along none-vol-static-boost
  typedef enum logic [1:0] {
    LHB_ARG_NONE   = 2'b00,
    LHB_ARG_VOL    = 2'b01,
    LHB_ARG_STATIC = 2'b11,
    LHB_ARG_BOOST  = 2'b10
  } lhb_arg_e;

  typedef struct packed {
    logic       display_on;
    logic [5:0] start_line;
    logic [3:0] page;
    logic [7:0] column;
    logic       col_reverse;
    logic       inverse;
    logic       all_on;
    logic       bias_1_7;
    logic       com_reverse;
    logic [2:0] power_ctrl;
    logic [2:0] ratio;
    logic [5:0] volume;
    logic [1:0] booster;
    logic       static_on;
    logic [1:0] static_mode;
    logic       rmw;
    logic [7:0] rmw_column;
  } lhb_cfg_s;

  typedef struct packed {
    logic       cs_n;
    logic       dc;
    logic       rd_e;
    logic       wr_rw;
    logic       par;
    logic       style;
    logic       init_n;
    logic [7:0] data;
  } lhb_pins_s;

  typedef struct packed {
    logic       dc;
    logic [7:0] data;
  } lhb_word_s;

  localparam lhb_cfg_s LHB_CFG_RST = '{volume: `LHB_VOLUME_RST,
                                       default: '0};

endpackage

/* File: lhb_host_bus.sv */
// Notes on behaviour
// - serial mode: line 7 is serial data, line 6 serial clock.
// - serial mode: data lines 0 to 5 are never driven.
// - chip deselected: all eight data lines released.
// - 8080 style: drive bus only while read strobe low and selected.
// - 6800 style: active-high enable pin strobes each access.
// - 8080 style: data captured on rising edge of store strobe.
// - 6800 style: direction high reads, low writes.
// - address bit zero high marks display data, low marks control.
// - transfers accepted only while chip select is low.
// - hardware init low clears all settings, by level.
// - display on/off command: bit 0 clear is off, set is on.
// - start-line command loads top display line from operand.
// - page-address command loads page pointer from operand.
// - column pointer loaded by upper and lower nibble commands.
// - display data write stores byte at current page and column.
// - column-order command: bit clear normal, set reversed.
// - normal/inverse command: bit clear direct, set inverted.
// - all-points command forces every dot on, memory untouched.
// - bias command: bit clear selects 1/9, set selects 1/7.
// - read-modify-write: column +1 on write, held on read, until end.
// - reset command resets settings without the init input.
`timescale 1ns/100ps
`include "lhb_consts.svh"
// ----------------------------------------------------------------------
// byte buffer between the host port and the command decoder
// ----------------------------------------------------------------------
module lhb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             clr_i,
  input  wire logic             in_valid_i,
  output      logic             in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output      logic             out_valid_o,
  input  wire logic             out_ready_i,
  output      logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("lhb_fifo depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } lhb_fifo_s;

  lhb_fifo_s        r;
  lhb_fifo_s        n;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign out_valid_o = (r.wr != r.rd);
  assign in_ready_o  = (r.wr[AW-1:0] != r.rd[AW-1:0]) || (r.wr[AW] == r.rd[AW]);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem[r.rd[AW-1:0]];

  always_comb begin
    n = r;
    if (clr_i) begin
      n.wr = '0;
      n.rd = '0;
    end else begin
      if (push) begin
        n.wr = r.wr + 1'b1;
      end
      if (pop) begin
        n.rd = r.rd + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // storage needs no reset; empty/full come from the pointers alone
  always_ff @(posedge clk_i) begin
    if (push && !clr_i) begin
      mem[r.wr[AW-1:0]] <= in_data_i;
    end
  end
endmodule

// ----------------------------------------------------------------------
// host port, serial shifter, command decoder and display memory
// ----------------------------------------------------------------------
module lhb_host_bus
  import lhb_pkg::*;
#(
  parameter int PAGES      = `LHB_PAGES,
  parameter int COLS       = `LHB_COLS,
  parameter int FIFO_DEPTH = `LHB_FIFO_DEPTH,
  parameter int MAW        = $clog2(`LHB_PAGES * `LHB_COLS)
) (
  input  wire logic           clk_i,
  input  wire logic           reset_n_i,
  input  wire logic           chip_select_n_i,
  input  wire logic           address_bit_zero_i,
  input  wire logic           rd_e_i,
  input  wire logic           wr_rw_i,
  input  wire logic           parallel_select_i,
  input  wire logic           bus_style_select_i,
  input  wire logic           hard_init_n_i,
  input  wire logic [7:0]     data_i,
  output      logic [7:0]     data_o,
  output      logic [7:0]     data_oe_o,
  output      logic           fifo_ready_o,
  output      lhb_cfg_s       cfg_o,
  input  wire logic [MAW-1:0] scan_addr_i,
  output      logic [7:0]     scan_data_o
);
  if (MAW != $clog2(PAGES * COLS) || COLS > 256 || PAGES > 16)
  begin : g_bad_geometry
    $error("lhb_host_bus memory geometry out of range");
  end

  typedef struct packed {
    lhb_pins_s  sync1;
    lhb_pins_s  sync2;
    lhb_pins_s  prev;
    logic [6:0] shift;
    logic [2:0] bitcnt;
    lhb_cfg_s   cfg;
    lhb_arg_e   arg;
    logic [7:0] rd_data;
    logic [7:0] scan_data;
  } lhb_state_s;

  lhb_state_s       r;
  lhb_state_s       n;
  lhb_pins_s        pins;
  lhb_pins_s        s;
  lhb_pins_s        p;
  logic [7:0]       dmem [PAGES*COLS];
  logic             mem_we;
  logic [MAW-1:0]   mem_waddr;
  logic [7:0]       mem_wdata;
  logic [7:0]       mem_rdata;
  logic             push;
  lhb_word_s        push_word;
  logic             pop;
  logic             out_valid;
  lhb_word_s        out_word;
  logic             sel;
  logic             drive;
  logic             wr_event;
  logic             rd_end;
  logic             addr_ok;
  logic             init_low;

  function automatic logic [MAW-1:0] mem_addr(input logic [3:0] page,
                                              input logic [7:0] col);
    logic [31:0] a;
    a = 32'(page) * 32'(COLS) + 32'(col);
    return a[MAW-1:0];
  endfunction

  function automatic logic hit(input logic [7:0] b,
                               input logic [7:0] code,
                               input logic [7:0] mask);
    return (b & mask) == code;
  endfunction

  // ----------------------------------------------------------------------
  // pin sampling: two flip-flops before any logic, third stage for edges
  // ----------------------------------------------------------------------
  assign pins = '{cs_n: chip_select_n_i, dc: address_bit_zero_i,
                  rd_e: rd_e_i, wr_rw: wr_rw_i, par: parallel_select_i,
                  style: bus_style_select_i, init_n: hard_init_n_i,
                  data: data_i};
  assign s        = r.sync2;
  assign p        = r.prev;
  assign init_low = !s.init_n;
  assign sel      = !s.cs_n;
  assign addr_ok  = (32'(r.cfg.page) < 32'(PAGES))
                 && (32'(r.cfg.column) < 32'(COLS));
  assign mem_rdata = dmem[mem_addr(r.cfg.page, r.cfg.column)];

  // bus drive: parallel only, selected, strobe in its read phase
  always_comb begin
    drive = 1'b0;
    if (s.par && sel) begin
      if (s.style) begin
        drive = s.rd_e && s.wr_rw;
      end else begin
        drive = !s.rd_e;
      end
    end
  end

  // write and read-completion events on the parallel port
  always_comb begin
    wr_event = 1'b0;
    rd_end   = 1'b0;
    if (s.par && sel) begin
      if (s.style) begin
        wr_event = p.rd_e && !s.rd_e && !s.wr_rw;
        rd_end   = p.rd_e && !s.rd_e && s.wr_rw;
      end else begin
        wr_event = !p.wr_rw && s.wr_rw;
        rd_end   = !p.rd_e && s.rd_e;
      end
    end
  end

  assign data_o      = r.rd_data;
  assign data_oe_o   = {8{drive}};
  assign cfg_o       = r.cfg;
  assign scan_data_o = r.scan_data;
  // a read in progress freezes the pointers the host is looking at
  assign pop         = out_valid && !drive && !rd_end;

  lhb_fifo #(
    .WIDTH ($bits(lhb_word_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .clr_i       (init_low),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready_o),
    .in_data_i   (push_word),
    .out_valid_o (out_valid),
    .out_ready_i (pop),
    .out_data_o  (out_word)
  );

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    n         = r;
    mem_we    = 1'b0;
    mem_waddr = '0;
    mem_wdata = '0;
    push      = 1'b0;
    push_word = '0;
    n.sync1   = pins;
    n.sync2   = r.sync1;
    n.prev    = r.sync2;
    n.scan_data = dmem[scan_addr_i];

    // parallel capture
    if (wr_event) begin
      push      = 1'b1;
      push_word = '{dc: s.dc, data: s.data};
    end

    // serial shifter; a deselect restarts the byte
    if (!s.par) begin
      if (!sel) begin
        n.bitcnt = '0;
      end else if (s.data[`LHB_SCL_BIT] && !p.data[`LHB_SCL_BIT]) begin
        n.shift  = {r.shift[5:0], s.data[`LHB_SI_BIT]};
        n.bitcnt = r.bitcnt + 1'b1;
        if (r.bitcnt == `LHB_SERIAL_LAST) begin
          push      = 1'b1;
          push_word = '{dc: s.dc, data: {r.shift, s.data[`LHB_SI_BIT]}};
        end
      end
    end

    // read data holds still while the host is reading it
    if (!drive) begin
      if (s.dc) begin
        n.rd_data = mem_rdata;
      end else begin
        n.rd_data = {out_valid, r.cfg.col_reverse, !r.cfg.display_on,
                     init_low, 4'h0};
      end
    end

    if (rd_end && s.dc && !r.cfg.rmw) begin
      n.cfg.column = r.cfg.column + 1'b1;
    end

    // command decoder
    if (pop) begin
      if (out_word.dc) begin
        mem_we       = addr_ok;
        mem_waddr    = mem_addr(r.cfg.page, r.cfg.column);
        mem_wdata    = out_word.data;
        n.cfg.column = r.cfg.column + 1'b1;
      end else if (r.arg != LHB_ARG_NONE) begin
        n.arg = LHB_ARG_NONE;
        case (r.arg)
          LHB_ARG_VOL: begin
            n.cfg.volume = out_word.data[5:0];
          end
          LHB_ARG_STATIC: begin
            n.cfg.static_mode = out_word.data[1:0];
          end
          LHB_ARG_BOOST: begin
            if (out_word.data[1:0] != `LHB_BOOST_BAD) begin
              n.cfg.booster = out_word.data[1:0];
            end
          end
          default: begin
            n.arg = LHB_ARG_NONE;
          end
        endcase
      end else begin
        if (hit(out_word.data, `LHB_ONOFF_CODE, `LHB_ONOFF_MASK)) begin
          n.cfg.display_on = out_word.data[0];
        end else if (hit(out_word.data, `LHB_START_CODE, `LHB_START_MASK))
        begin
          n.cfg.start_line = out_word.data[5:0];
        end else if (hit(out_word.data, `LHB_PAGE_CODE, `LHB_PAGE_MASK))
        begin
          n.cfg.page = out_word.data[3:0];
        end else if (hit(out_word.data, `LHB_COLH_CODE, `LHB_NIB_MASK)) begin
          n.cfg.column[7:4] = out_word.data[3:0];
        end else if (hit(out_word.data, `LHB_COLL_CODE, `LHB_NIB_MASK)) begin
          n.cfg.column[3:0] = out_word.data[3:0];
        end else if (hit(out_word.data, `LHB_ADC_CODE, `LHB_BIT0_MASK)) begin
          n.cfg.col_reverse = out_word.data[0];
        end else if (hit(out_word.data, `LHB_INV_CODE, `LHB_BIT0_MASK)) begin
          n.cfg.inverse = out_word.data[0];
        end else if (hit(out_word.data, `LHB_ALL_CODE, `LHB_BIT0_MASK)) begin
          n.cfg.all_on = out_word.data[0];
        end else if (hit(out_word.data, `LHB_BIAS_CODE, `LHB_BIT0_MASK)) begin
          n.cfg.bias_1_7 = out_word.data[0];
        end else if (hit(out_word.data, `LHB_STATIC_CODE, `LHB_BIT0_MASK))
        begin
          n.cfg.static_on = out_word.data[0];
          n.arg           = LHB_ARG_STATIC;
        end else if (out_word.data == `LHB_RMW_CODE) begin
          n.cfg.rmw        = 1'b1;
          n.cfg.rmw_column = r.cfg.column;
        end else if (out_word.data == `LHB_END_CODE) begin
          n.cfg.rmw = 1'b0;
          if (r.cfg.rmw) begin
            n.cfg.column = r.cfg.rmw_column;
          end
        end else if (out_word.data == `LHB_RESET_CODE) begin
          n.cfg = LHB_CFG_RST;
          n.arg = LHB_ARG_NONE;
        end else if (hit(out_word.data, `LHB_COM_CODE, `LHB_COM_MASK)) begin
          n.cfg.com_reverse = out_word.data[`LHB_COM_BIT];
        end else if (hit(out_word.data, `LHB_PWR_CODE, `LHB_LOW3_MASK)) begin
          n.cfg.power_ctrl = out_word.data[2:0];
        end else if (hit(out_word.data, `LHB_RATIO_CODE, `LHB_LOW3_MASK))
        begin
          n.cfg.ratio = out_word.data[2:0];
        end else if (out_word.data == `LHB_VOL_CODE) begin
          n.arg = LHB_ARG_VOL;
        end else if (out_word.data == `LHB_BOOST_CODE) begin
          n.arg = LHB_ARG_BOOST;
        end else begin
          n.arg = LHB_ARG_NONE;
        end
      end
    end

    // level-held init wins over everything the decoder did
    if (init_low) begin
      n.cfg    = LHB_CFG_RST;
      n.arg    = LHB_ARG_NONE;
      n.bitcnt = '0;
      mem_we   = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= '{cfg: LHB_CFG_RST, arg: LHB_ARG_NONE,
             sync1: '{cs_n: 1'b1, init_n: 1'b1, par: 1'b1,
                      rd_e: 1'b1, wr_rw: 1'b1, default: '0},
             sync2: '{cs_n: 1'b1, init_n: 1'b1, par: 1'b1,
                      rd_e: 1'b1, wr_rw: 1'b1, default: '0},
             prev:  '{cs_n: 1'b1, init_n: 1'b1, par: 1'b1,
                      rd_e: 1'b1, wr_rw: 1'b1, default: '0},
             default: '0};
    end else begin
      r <= n;
    end
  end

  // display memory keeps its contents across init and the reset command
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      dmem[mem_waddr] <= mem_wdata;
    end
  end
endmodule

/* File: lhb_host_model.sv */
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// host processor driving the parallel or serial port
// ----------------------------------------------------------------------
module lhb_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] bus_i,
  output      logic       cs_n_o,
  output      logic       dc_o,
  output      logic       rd_e_o,
  output      logic       wr_rw_o,
  output      logic       par_o,
  output      logic       style_o,
  output      logic [7:0] d_o
);
  initial begin
    cs_n_o = 1'b1;
    dc_o = 1'b0;
    rd_e_o = 1'b1;
    wr_rw_o = 1'b1;
    par_o = 1'b1;
    style_o = 1'b0;
    d_o = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // straps only move while deselected
  task automatic mode(input logic par, input logic style);
    par_o <= par;
    style_o <= style;
    rd_e_o <= ~style;
    wr_rw_o <= 1'b1;
    d_o <= par ? 8'h00 : 8'h3f;
    tick(4);
  endtask

  // phases of four cycles: the pins cross a synchroniser before use
  task automatic wr(input logic sel, input logic dc, input logic [7:0] b);
    cs_n_o <= ~sel;
    dc_o <= dc;
    d_o <= b;
    wr_rw_o <= 1'b0;
    tick(4);
    if (style_o) begin
      rd_e_o <= 1'b1;
      tick(4);
      rd_e_o <= 1'b0;
    end else
      wr_rw_o <= 1'b1;
    tick(4);
    wr_rw_o <= 1'b1;
    cs_n_o <= 1'b1;
    d_o <= ~b;
    tick(2);
  endtask

  task automatic rd(input logic dc, output logic [7:0] q);
    cs_n_o <= 1'b0;
    dc_o <= dc;
    d_o <= ~d_o;
    wr_rw_o <= 1'b1;
    tick(2);
    rd_e_o <= style_o;
    tick(5);
    q = bus_i;
    rd_e_o <= ~style_o;
    tick(5);
    cs_n_o <= 1'b1;
    tick(2);
  endtask

  task automatic sw(input logic dc, input logic [7:0] b);
    cs_n_o <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      d_o[7] <= b[i];
      d_o[6] <= 1'b0;
      if (i == 0) dc_o <= dc;
      tick(4);
      d_o[6] <= 1'b1;
      tick(4);
    end
    d_o[6] <= 1'b0;
    tick(4);
    cs_n_o <= 1'b1;
    tick(2);
  endtask
endmodule

/* File: lhb_host_bus_monitor.sv */
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// port checks; each pin level must stand four edges past the synchroniser
// ----------------------------------------------------------------------
module lhb_host_bus_monitor
  import lhb_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  input wire logic       chip_select_n_i,
  input wire logic       rd_e_i,
  input wire logic       wr_rw_i,
  input wire logic       parallel_select_i,
  input wire logic       bus_style_select_i,
  input wire logic       hard_init_n_i,
  input wire logic [7:0] data_oe_o,
  input wire lhb_cfg_s   cfg_o
);
  logic [4:0] quiet_reg;

  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i) quiet_reg <= 5'h00;
    else if (!chip_select_n_i || !hard_init_n_i) quiet_reg <= 5'h00;
    else if (quiet_reg != 5'h1f) quiet_reg <= quiet_reg + 5'h01;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_rd8080;
    (parallel_select_i && !bus_style_select_i && !chip_select_n_i
     && !rd_e_i) [*4];
  endsequence
  sequence s_rd6800;
    (parallel_select_i && bus_style_select_i && !chip_select_n_i
     && rd_e_i && wr_rw_i) [*4];
  endsequence

  oe_desel_a: assert property (
    chip_select_n_i [*4] |-> data_oe_o == 8'h00)
    else $error("data bus driven while deselected");
  oe_serial_a: assert property (
    !parallel_select_i [*4] |-> data_oe_o == 8'h00)
    else $error("data bus driven in serial mode");
  rd_idle_a: assert property (
    (!bus_style_select_i && rd_e_i) [*4] |-> data_oe_o == 8'h00)
    else $error("data bus driven without read strobe");
  rd_drive_a: assert property (
    s_rd8080 |-> data_oe_o == 8'hff)
    else $error("read strobe did not drive the bus");
  e_drive_a: assert property (
    s_rd6800 |-> data_oe_o == 8'hff)
    else $error("enable read did not drive the bus");
  w_quiet_a: assert property (
    (bus_style_select_i && !wr_rw_i) [*4] |-> data_oe_o == 8'h00)
    else $error("data bus driven during a write access");
  init_clear_a: assert property (
    !hard_init_n_i [*4] |-> cfg_o == LHB_CFG_RST)
    else $error("settings not cleared by hardware init");
  cfg_hold_a: assert property (
    quiet_reg >= 5'h18 |-> $stable(cfg_o))
    else $error("settings changed while deselected");
endmodule

bind lhb_host_bus lhb_host_bus_monitor u_monitor (
  .clk_i(clk_i), .reset_n_i(reset_n_i),
  .chip_select_n_i(chip_select_n_i), .rd_e_i(rd_e_i), .wr_rw_i(wr_rw_i),
  .parallel_select_i(parallel_select_i),
  .bus_style_select_i(bus_style_select_i), .hard_init_n_i(hard_init_n_i),
  .data_oe_o(data_oe_o), .cfg_o(cfg_o));

/* File: test_lhb_host_bus.sv */
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// command sequences through all three host links
// ----------------------------------------------------------------------
module test_lhb_host_bus;
  import lhb_pkg::*;
  localparam logic C = 1'b0;
  localparam logic D = 1'b1;
  logic       clk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic       hard_init_n = 1'b1;
  logic       ready;
  logic [9:0] scan_addr = 10'h000;
  logic       cs_n, dc, rd_e, wr_rw, par, style;
  logic [7:0] host_d, data_o, data_oe, scan_data, q;
  wire  [7:0] bus = (data_oe & data_o) | (~data_oe & host_d);
  lhb_cfg_s   cfg, e;
  logic [1:0] boost [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
  int         n_mismatch = 0;
  int         checked = 0;

  always #50 clk_i = ~clk_i;

  lhb_host_model HOST (
    .clk_i(clk_i), .bus_i(bus), .cs_n_o(cs_n), .dc_o(dc), .rd_e_o(rd_e),
    .wr_rw_o(wr_rw), .par_o(par), .style_o(style), .d_o(host_d));

  lhb_host_bus DUT (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .chip_select_n_i(cs_n),
    .address_bit_zero_i(dc), .rd_e_i(rd_e), .wr_rw_i(wr_rw),
    .parallel_select_i(par), .bus_style_select_i(style),
    .hard_init_n_i(hard_init_n), .data_i(bus), .data_o(data_o),
    .data_oe_o(data_oe), .fifo_ready_o(ready), .cfg_o(cfg),
    .scan_addr_i(scan_addr), .scan_data_o(scan_data));

  task automatic complete_run;
    if (n_mismatch == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: byte %h, want %h", $time, got, exp);
    end
  endtask

  // the column saved for read-modify-write is internal scratch, not compared
  task automatic chk_cfg;
    lhb_cfg_s g;
    g = cfg;
    g.rmw_column = e.rmw_column;
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: cfg %h, want %h", $time, g, e);
    end
  endtask

  task automatic xw(input logic dc_v, input logic [7:0] b);
    if (par) HOST.wr(1'b1, dc_v, b);
    else HOST.sw(dc_v, b);
    HOST.tick(6);
    chk_cfg;
  endtask

  task automatic setcol(input logic [7:0] c);
    e.column = {c[7:4], e.column[3:0]};
    xw(C, {4'h1, c[7:4]});
    e.column = c;
    xw(C, {4'h0, c[3:0]});
  endtask

  task automatic scan(input logic [9:0] a, input logic [7:0] exp);
    scan_addr <= a;
    HOST.tick(2);
    chk_byte(scan_data, exp);
  endtask

  initial begin
    #1000000;
    n_mismatch++;
    $display("unexpected at %0t: run too long", $time);
    complete_run;
  end

  initial begin
    e = LHB_CFG_RST;
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    HOST.mode(1'b1, 1'b0);
    chk_cfg;
    e.display_on = 1'b1;
    xw(C, 8'haf);
    e.start_line = 6'h2a;
    xw(C, 8'h6a);
    e.page = 4'h3;
    xw(C, 8'hb3);
    setcol(8'h5c);
    e.col_reverse = 1'b1;
    xw(C, 8'ha1);
    e.inverse = 1'b1;
    xw(C, 8'ha7);
    e.all_on = 1'b1;
    xw(C, 8'ha5);
    e.bias_1_7 = 1'b1;
    xw(C, 8'ha3);
    xw(C, 8'he3);
    HOST.wr(1'b0, C, 8'hae);
    HOST.tick(6);
    chk_cfg;
    e.column = 8'h5d;
    xw(D, 8'h96);
    scan(10'h1dc, 8'h96);
    HOST.rd(C, q);
    chk_byte(q, 8'h40);
    setcol(8'h5c);
    e.rmw = 1'b1;
    xw(C, 8'he0);
    HOST.rd(D, q);
    chk_byte(q, 8'h96);
    chk_cfg;
    e.column = 8'h5d;
    xw(D, 8'h3c);
    scan(10'h1dc, 8'h3c);
    e.rmw = 1'b0;
    e.column = 8'h5c;
    xw(C, 8'hee);
    HOST.rd(D, q);
    chk_byte(q, 8'h3c);
    e.column = 8'h5d;
    chk_cfg;
    HOST.mode(1'b1, 1'b1);
    e.display_on = 1'b0;
    xw(C, 8'hae);
    HOST.rd(C, q);
    chk_byte(q, 8'h60);
    e.col_reverse = 1'b0;
    xw(C, 8'ha0);
    xw(C, 8'h81);
    e.volume = 6'h15;
    xw(C, 8'h15);
    foreach (boost[i]) begin
      xw(C, 8'hf8);
      if (boost[i] != 2'h2) e.booster = boost[i];
      xw(C, {6'h00, boost[i]});
    end
    e.com_reverse = 1'b1;
    xw(C, 8'hc8);
    e.power_ctrl = 3'h7;
    xw(C, 8'h2f);
    e.ratio = 3'h5;
    xw(C, 8'h25);
    e.static_on = 1'b1;
    xw(C, 8'had);
    e.static_mode = 2'h2;
    xw(C, 8'h02);
    HOST.mode(1'b0, 1'b0);
    e.inverse = 1'b0;
    xw(C, 8'ha6);
    e.column = 8'h5e;
    xw(D, 8'h5a);
    scan(10'h1dd, 8'h5a);
    e = LHB_CFG_RST;
    xw(C, 8'he2);
    HOST.mode(1'b1, 1'b0);
    e.display_on = 1'b1;
    xw(C, 8'haf);
    hard_init_n <= 1'b0;
    HOST.tick(8);
    e = LHB_CFG_RST;
    chk_cfg;
    chk_byte({7'h00, ready}, 8'h01);
    HOST.rd(C, q);
    chk_byte(q, 8'h30);
    hard_init_n <= 1'b1;
    HOST.tick(30);
    complete_run;
  end
endmodule
